// ==== shared/mof_pkg.sv ====
// Constants and types shared by the memory ordering fence unit and its store buffer.
// Assumes a single core clock and a synchronous active-low reset.
//
// Contract
// - Port I/O waits for older instructions done and store buffer drained.
// - While port I/O is outstanding only fetches and table walks may issue.
// - No younger instruction starts until the port access completes.
// - Locked read-modify-write is atomic; no other agent intervenes.
// - Locked operation waits for older instructions and drained stores first.
// - Serializing instruction waits for older instructions and drained stores.
// - Store fence orders older stores before younger stores; loads free.
// - Load fence orders older loads before younger loads; stores free.
// - Full fence orders all older loads and stores before later accesses.
// - Every uncached access appears on the bus individually.
// - Uncached accesses are never speculative nor out of order.
// - Write-back reads may be speculative; writes may buffer and combine.
// - Write-back atomic within one line locks the cache line, not bus.
// - Atomic not cache-lockable holds bus lock for the whole sequence.
// - Only uncached regions guarantee strict program order traffic.
// - Write-back loads bypass stores but get own pending store data.
// - Stores reach memory only after their instruction retired.
package mof_pkg;

	// ----------------------------------------------------------------
	// Widths and sizes
	// ----------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int SB_DEPTH = 4;
	localparam int SB_IDX_W = 2;
	localparam int LINE_OFS_W = 6;
	localparam int OUT_W = 4;
	localparam logic [OUT_W-1:0] OUT_ZERO = 4'h0;
	localparam logic [SB_IDX_W:0] SB_CNT_ZERO = 3'h0;
	localparam logic [SB_IDX_W:0] SB_CNT_FULL = 3'h4;

	// ----------------------------------------------------------------
	// Operation kinds presented by the retirement stream
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MOF_OP_LOAD,
		MOF_OP_STORE,
		MOF_OP_PORT_IN,
		MOF_OP_PORT_OUT,
		MOF_OP_LOCKED_RMW,
		MOF_OP_SERIALIZE,
		MOF_OP_STORE_FENCE,
		MOF_OP_LOAD_FENCE,
		MOF_OP_FULL_FENCE
	} mof_op_t;

	// Bus cycle kinds issued to the memory subsystem.
	typedef enum logic [1:0] {
		MOF_BUS_READ,
		MOF_BUS_WRITE,
		MOF_BUS_PORT_RD,
		MOF_BUS_PORT_WR
	} mof_bus_t;

	// Sequencer states of the ordering unit.
	typedef enum logic [2:0] {
		MOF_ST_IDLE,
		MOF_ST_DRAIN,
		MOF_ST_ISSUE,
		MOF_ST_WAIT,
		MOF_ST_RMW_WR,
		MOF_ST_RMW_ACK
	} mof_state_t;

endpackage

// ==== shared/mof_sb_if.sv ====
// Interface between the ordering unit and its store buffer.
// Assumes both ends run on the core clock.
`timescale 1ns/1ns
interface mof_sb_if;
	logic push;
	logic [mof_pkg::ADDR_W-1:0] push_addr;
	logic [mof_pkg::DATA_W-1:0] push_data;
	logic push_wb;
	logic full;
	logic empty;
	logic head_valid;
	logic [mof_pkg::ADDR_W-1:0] head_addr;
	logic [mof_pkg::DATA_W-1:0] head_data;
	logic pop;
	logic [mof_pkg::ADDR_W-1:0] look_addr;
	logic look_hit;
	logic [mof_pkg::DATA_W-1:0] look_data;

	modport ctrl (
		output push, push_addr, push_data, push_wb, pop, look_addr,
		input full, empty, head_valid, head_addr, head_data, look_hit, look_data
	);
	modport buf_side (
		input push, push_addr, push_data, push_wb, pop, look_addr,
		output full, empty, head_valid, head_addr, head_data, look_hit, look_data
	);
endinterface

// ==== rtl/mof_store_buffer.sv ====
// Store buffer holding retired stores until they are sent to memory.
// Assumes pushes come only from retired stores and pops when the head is sent.
`timescale 1ns/1ns
module mof_store_buffer (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rstn_i,
	// Connection to the ordering unit.
	mof_sb_if.buf_side sb
);
	typedef struct packed {
		logic [mof_pkg::SB_DEPTH-1:0][mof_pkg::ADDR_W-1:0] addr;
		logic [mof_pkg::SB_DEPTH-1:0][mof_pkg::DATA_W-1:0] data;
		logic [mof_pkg::SB_DEPTH-1:0] wb;
		logic [mof_pkg::SB_IDX_W-1:0] rd;
		logic [mof_pkg::SB_IDX_W-1:0] wr;
		logic [mof_pkg::SB_IDX_W:0] cnt;
	} mof_sb_state_t;

	mof_sb_state_t s_reg;
	mof_sb_state_t s_next;
	logic comb_hit;
	logic [mof_pkg::SB_IDX_W-1:0] tail;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Combining merges only into the youngest entry, and only for write-back,
	// so younger stores never overtake older ones on the bus.
	always_comb begin
		s_next = s_reg;
		tail = s_reg.wr - 2'h1;
		comb_hit = sb.push && s_reg.cnt > 3'h1 && s_reg.wb[tail] && sb.push_wb
			&& s_reg.addr[tail] == sb.push_addr;
		if (sb.pop && s_reg.cnt != mof_pkg::SB_CNT_ZERO) begin
			s_next.rd = s_reg.rd + 2'h1;
			s_next.cnt = s_next.cnt - 3'h1;
		end
		if (comb_hit) begin
			s_next.data[tail] = sb.push_data;
		end else if (sb.push && s_reg.cnt != mof_pkg::SB_CNT_FULL) begin
			s_next.addr[s_reg.wr] = sb.push_addr;
			s_next.data[s_reg.wr] = sb.push_data;
			s_next.wb[s_reg.wr] = sb.push_wb;
			s_next.wr = s_reg.wr + 2'h1;
			s_next.cnt = s_next.cnt + 3'h1;
		end
	end

	// Register the whole state.
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Status and forwarding lookup
	// ----------------------------------------------------------------
	// The youngest matching entry wins so a load sees its latest own store.
	always_comb begin
		sb.look_hit = 1'b0;
		sb.look_data = '0;
		for (int i = 0; i < mof_pkg::SB_DEPTH; i++) begin
			if (3'(i) < s_reg.cnt && s_reg.addr[s_reg.rd + 2'(i)] == sb.look_addr) begin
				sb.look_hit = 1'b1;
				sb.look_data = s_reg.data[s_reg.rd + 2'(i)];
			end
		end
	end

	assign sb.full = s_reg.cnt == mof_pkg::SB_CNT_FULL;
	assign sb.empty = s_reg.cnt == mof_pkg::SB_CNT_ZERO;
	assign sb.head_valid = !sb.empty;
	assign sb.head_addr = s_reg.addr[s_reg.rd];
	assign sb.head_data = s_reg.data[s_reg.rd];
endmodule

// ==== rtl/mof_fence_unit.sv ====
// Memory ordering fence unit: admits retired operations in program order and
// sequences store drains, port accesses, locked operations and fences.
// Assumes one operation offered at a time by the retirement stream, and a
// memory subsystem that answers each bus cycle with one acknowledge pulse.
`timescale 1ns/1ns
module mof_fence_unit (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rstn_i,
	// Operation stream from retirement.
	input wire logic op_valid_i,
	input wire mof_pkg::mof_op_t op_kind_i,
	input wire logic [mof_pkg::ADDR_W-1:0] op_addr_i,
	input wire logic [mof_pkg::DATA_W-1:0] op_data_i,
	input wire logic op_uncached_i,
	input wire logic older_done_i,
	output logic op_ready_o,
	output logic resp_valid_o,
	output logic [mof_pkg::DATA_W-1:0] resp_data_o,
	// Memory subsystem bus.
	output logic bus_req_o,
	output mof_pkg::mof_bus_t bus_kind_o,
	output logic [mof_pkg::ADDR_W-1:0] bus_addr_o,
	output logic [mof_pkg::DATA_W-1:0] bus_data_o,
	output logic bus_lock_o,
	output logic line_lock_o,
	input wire logic bus_gnt_i,
	input wire logic bus_ack_i,
	input wire logic [mof_pkg::DATA_W-1:0] bus_rdata_i,
	// Status.
	output logic drained_o
);
	typedef struct packed {
		mof_pkg::mof_state_t st;
		mof_pkg::mof_op_t op;
		logic [mof_pkg::ADDR_W-1:0] addr;
		logic [mof_pkg::DATA_W-1:0] data;
		logic [mof_pkg::OUT_W-1:0] out_wr;
		logic ready;
		logic resp_valid;
		logic [mof_pkg::DATA_W-1:0] resp_data;
		logic req;
		mof_pkg::mof_bus_t kind;
		logic [mof_pkg::ADDR_W-1:0] baddr;
		logic [mof_pkg::DATA_W-1:0] bdata;
		logic bus_lock;
		logic line_lock;
		logic drained;
	} mof_state_reg_t;

	mof_state_reg_t s_reg;
	mof_state_reg_t s_next;
	mof_sb_if sb();
	logic quiet;
	logic needs_drain;
	logic take;

	mof_store_buffer u_sb (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.sb(sb)
	);

	// Does an atomic fit inside one cache line (4-byte access assumed).
	function automatic logic in_one_line(input logic [mof_pkg::ADDR_W-1:0] a);
		in_one_line = a[mof_pkg::LINE_OFS_W-1:0] <= 6'h3c;
	endfunction

	// Operations that need every older store written and acknowledged.
	function automatic logic drain_kind(input mof_pkg::mof_op_t k, input logic unc);
		drain_kind = k == mof_pkg::MOF_OP_PORT_IN || k == mof_pkg::MOF_OP_PORT_OUT
			|| k == mof_pkg::MOF_OP_LOCKED_RMW || k == mof_pkg::MOF_OP_SERIALIZE
			|| k == mof_pkg::MOF_OP_STORE_FENCE || k == mof_pkg::MOF_OP_FULL_FENCE
			|| (unc && (k == mof_pkg::MOF_OP_LOAD || k == mof_pkg::MOF_OP_STORE));
	endfunction

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Quiet means store buffer empty, nothing on the bus and no write waiting
	// for its acknowledge.
	always_comb begin
		quiet = sb.empty && s_reg.out_wr == mof_pkg::OUT_ZERO && !s_reg.req;
		needs_drain = drain_kind(op_kind_i, op_uncached_i);
		sb.look_addr = op_addr_i;
		sb.push = 1'b0;
		sb.push_addr = op_addr_i;
		sb.push_data = op_data_i;
		sb.push_wb = !op_uncached_i;
		sb.pop = 1'b0;
		take = 1'b0;
		s_next = s_reg;
		s_next.resp_valid = 1'b0;
		s_next.ready = 1'b0;
		// Count buffered writes issued but not yet acknowledged. Acks return in order and
		// buffered writes always go out first, so the first out_wr acks are theirs.
		if (bus_ack_i && s_reg.out_wr != mof_pkg::OUT_ZERO) begin
			s_next.out_wr = s_reg.out_wr - 4'h1;
		end
		// A granted request drops one cycle later.
		if (s_reg.req && bus_gnt_i) begin
			s_next.req = 1'b0;
		end
		// Background drain of retired stores; only in idle and drain so that nothing
		// is added to the bus while a port or locked access is in flight.
		if (s_reg.st == mof_pkg::MOF_ST_IDLE || s_reg.st == mof_pkg::MOF_ST_DRAIN) begin
			if (!s_next.req && sb.head_valid && s_reg.out_wr != 4'hf) begin
				sb.pop = 1'b1;
				s_next.req = 1'b1;
				s_next.kind = mof_pkg::MOF_BUS_WRITE;
				s_next.baddr = sb.head_addr;
				s_next.bdata = sb.head_data;
				s_next.out_wr = s_next.out_wr + 4'h1;
			end
		end
		case (s_reg.st)
			mof_pkg::MOF_ST_IDLE: begin
				if (op_valid_i && s_reg.ready) begin
					take = 1'b1;
					s_next.op = op_kind_i;
					s_next.addr = op_addr_i;
					s_next.data = op_data_i;
					if (needs_drain) begin
						s_next.st = mof_pkg::MOF_ST_DRAIN;
					end else if (op_kind_i == mof_pkg::MOF_OP_STORE && !sb.full) begin
						sb.push = 1'b1;
						s_next.ready = 1'b1;
					end else if (op_kind_i == mof_pkg::MOF_OP_STORE) begin
						s_next.st = mof_pkg::MOF_ST_DRAIN;
					end else if (op_kind_i == mof_pkg::MOF_OP_LOAD && sb.look_hit) begin
						s_next.resp_valid = 1'b1;
						s_next.resp_data = sb.look_data;
						s_next.ready = 1'b1;
					end else if (op_kind_i == mof_pkg::MOF_OP_LOAD) begin
						s_next.st = mof_pkg::MOF_ST_ISSUE;
					end else begin
						// A load fence completes here: loads are answered in
						// order and one at a time, so older loads are done.
						s_next.ready = 1'b1;
					end
				end else begin
					s_next.ready = 1'b1;
				end
			end
			mof_pkg::MOF_ST_DRAIN: begin
				if (quiet && older_done_i) begin
					if (s_reg.op == mof_pkg::MOF_OP_STORE_FENCE || s_reg.op == mof_pkg::MOF_OP_FULL_FENCE
						|| s_reg.op == mof_pkg::MOF_OP_SERIALIZE) begin
						s_next.st = mof_pkg::MOF_ST_IDLE;
						s_next.ready = 1'b1;
					end else if (s_reg.op == mof_pkg::MOF_OP_STORE && op_uncached_i) begin
						s_next.st = mof_pkg::MOF_ST_ISSUE;
					end else if (s_reg.op == mof_pkg::MOF_OP_STORE) begin
						sb.push = 1'b1;
						sb.push_addr = s_reg.addr;
						sb.push_data = s_reg.data;
						s_next.st = mof_pkg::MOF_ST_IDLE;
						s_next.ready = 1'b1;
					end else begin
						s_next.st = mof_pkg::MOF_ST_ISSUE;
					end
				end
			end
			mof_pkg::MOF_ST_ISSUE: begin
				// A write-back load may find a buffered write still waiting for
				// its grant; that request is left standing, never overwritten.
				if (!s_next.req) begin
					s_next.req = 1'b1;
					s_next.baddr = s_reg.addr;
					s_next.bdata = s_reg.data;
					s_next.st = mof_pkg::MOF_ST_WAIT;
					case (s_reg.op)
						mof_pkg::MOF_OP_PORT_IN: s_next.kind = mof_pkg::MOF_BUS_PORT_RD;
						mof_pkg::MOF_OP_PORT_OUT: s_next.kind = mof_pkg::MOF_BUS_PORT_WR;
						mof_pkg::MOF_OP_STORE: s_next.kind = mof_pkg::MOF_BUS_WRITE;
						default: s_next.kind = mof_pkg::MOF_BUS_READ;
					endcase
					if (s_reg.op == mof_pkg::MOF_OP_LOCKED_RMW) begin
						s_next.line_lock = !op_uncached_i && in_one_line(s_reg.addr);
						s_next.bus_lock = op_uncached_i || !in_one_line(s_reg.addr);
					end
				end
			end
			mof_pkg::MOF_ST_WAIT: begin
				if (bus_ack_i && !s_reg.req && s_reg.out_wr == mof_pkg::OUT_ZERO) begin
					s_next.resp_valid = s_reg.op != mof_pkg::MOF_OP_PORT_OUT && s_reg.op != mof_pkg::MOF_OP_STORE;
					s_next.resp_data = bus_rdata_i;
					if (s_reg.op == mof_pkg::MOF_OP_LOCKED_RMW) begin
						s_next.st = mof_pkg::MOF_ST_RMW_WR;
					end else begin
						s_next.st = mof_pkg::MOF_ST_IDLE;
						s_next.ready = 1'b1;
					end
				end
			end
			mof_pkg::MOF_ST_RMW_WR: begin
				// Write the new value back under the same lock.
				s_next.req = 1'b1;
				s_next.kind = mof_pkg::MOF_BUS_WRITE;
				s_next.st = mof_pkg::MOF_ST_RMW_ACK;
			end
			mof_pkg::MOF_ST_RMW_ACK: begin
				if (bus_ack_i && !s_reg.req && s_reg.out_wr == mof_pkg::OUT_ZERO) begin
					s_next.bus_lock = 1'b0;
					s_next.line_lock = 1'b0;
					s_next.st = mof_pkg::MOF_ST_IDLE;
					s_next.ready = 1'b1;
				end
			end
			default: s_next.st = mof_pkg::MOF_ST_IDLE;
		endcase
		if (take) begin
			s_next.ready = s_next.ready && s_next.st == mof_pkg::MOF_ST_IDLE;
		end
		s_next.drained = sb.empty && s_next.out_wr == mof_pkg::OUT_ZERO && !s_next.req;
	end

	// Register the whole state.
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign op_ready_o = s_reg.ready;
	assign resp_valid_o = s_reg.resp_valid;
	assign resp_data_o = s_reg.resp_data;
	assign bus_req_o = s_reg.req;
	assign bus_kind_o = s_reg.kind;
	assign bus_addr_o = s_reg.baddr;
	assign bus_data_o = s_reg.bdata;
	assign bus_lock_o = s_reg.bus_lock;
	assign line_lock_o = s_reg.line_lock;
	assign drained_o = s_reg.drained;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_port_after_drain: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(bus_req_o) && bus_kind_o inside {mof_pkg::MOF_BUS_PORT_RD, mof_pkg::MOF_BUS_PORT_WR}
		|-> $past(sb.empty) && $past(s_reg.out_wr) == mof_pkg::OUT_ZERO)
		else $error("Port access issued before store drain.");
	a_no_pop_in_io: assert property (@(posedge clock_i) disable iff (!rstn_i)
		s_reg.st == mof_pkg::MOF_ST_WAIT |-> !sb.pop)
		else $error("Store drained while port or locked access pending.");
	a_no_take_in_io: assert property (@(posedge clock_i) disable iff (!rstn_i)
		s_reg.st == mof_pkg::MOF_ST_WAIT && !bus_ack_i |=> !op_ready_o)
		else $error("Younger operation accepted before port access completed.");
	a_lock_held_rmw: assert property (@(posedge clock_i) disable iff (!rstn_i)
		s_reg.st == mof_pkg::MOF_ST_RMW_WR |-> (bus_lock_o || line_lock_o) && $stable(bus_lock_o))
		else $error("Lock dropped inside read-modify-write.");
	a_line_lock_wb: assert property (@(posedge clock_i) disable iff (!rstn_i)
		line_lock_o |-> !bus_lock_o)
		else $error("Bus lock used with cache line lock.");
	a_fence_quiet: assert property (@(posedge clock_i) disable iff (!rstn_i)
		s_reg.st == mof_pkg::MOF_ST_DRAIN ##1 s_reg.st == mof_pkg::MOF_ST_IDLE
		|-> $past(s_reg.out_wr) == mof_pkg::OUT_ZERO)
		else $error("Drain ended with writes unacknowledged.");
	a_drained_flag: assert property (@(posedge clock_i) disable iff (!rstn_i)
		drained_o |-> ##0 s_reg.out_wr == mof_pkg::OUT_ZERO && !bus_req_o)
		else $error("Drained flag raised with traffic outstanding.");
	a_rmw_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
		s_reg.st == mof_pkg::MOF_ST_RMW_WR |=> bus_req_o && bus_kind_o == mof_pkg::MOF_BUS_WRITE)
		else $error("Locked write-back cycle missing.");
endmodule

// ==== testbench/mof_mem_model.sv ====
// Behavioural memory subsystem on the far side of the fence unit's bus.
// Assumes one request at a time; grants after lat_i waits, acks in order.
`timescale 1ns/1ns
module mof_mem_model (
	// Clock, reset and pacing.
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [3:0] lat_i,
	// Bus from the unit.
	input wire logic bus_req_i,
	input wire mof_pkg::mof_bus_t bus_kind_i,
	input wire logic [31:0] bus_addr_i,
	input wire logic [31:0] bus_data_i,
	// Answers to the unit, and the open cycle count for the bench.
	output logic bus_gnt_o,
	output logic bus_ack_o,
	output logic [31:0] bus_rdata_o,
	output logic [3:0] pend_o
);
	logic [31:0] mem [logic [31:0]];
	logic [64:0] q [$];
	logic [64:0] cur;
	logic [3:0] gnt_cnt;
	logic [3:0] ack_cnt;

	// Acks are served before grants so that no cycle is acked on its grant edge.
	// Read data flips every idle cycle, since a released bus holds no value.
	// Pend counts the cycles still open ahead of a newly granted one.
	always @(posedge clock_i) begin
		bus_gnt_o <= 1'b0;
		bus_ack_o <= 1'b0;
		bus_rdata_o <= ~bus_rdata_o;
		if (!rstn_i) begin
			q.delete();
			gnt_cnt <= 4'h0;
			ack_cnt <= 4'h0;
			bus_rdata_o <= 32'h0000_0000;
			pend_o <= 4'h0;
		end else begin
			if (q.size() > 0 && ack_cnt >= lat_i) begin
				cur = q.pop_front();
				bus_ack_o <= 1'b1;
				ack_cnt <= 4'h0;
				if (cur[64])
					mem[cur[63:32]] = cur[31:0];
				else
					bus_rdata_o <= mem.exists(cur[63:32]) ? mem[cur[63:32]] : cur[63:32] ^ 32'h5a5a_5a5a;
			end else if (q.size() > 0) begin
				ack_cnt <= ack_cnt + 4'h1;
			end
			pend_o <= 4'(q.size());
			if (bus_req_i && !bus_gnt_o && gnt_cnt >= lat_i) begin
				bus_gnt_o <= 1'b1;
				gnt_cnt <= 4'h0;
				q.push_back({bus_kind_i == mof_pkg::MOF_BUS_WRITE || bus_kind_i == mof_pkg::MOF_BUS_PORT_WR,
					bus_addr_i, bus_data_i});
			end else if (bus_req_i && !bus_gnt_o) begin
				gnt_cnt <= gnt_cnt + 4'h1;
			end
		end
	end
endmodule

// ==== testbench/mof_fence_unit_tb.sv ====
// Self-checking bench for the memory ordering fence unit.
// Assumes the memory model beside it answers every bus cycle in order.
`timescale 1ns/1ns
module mof_fence_unit_tb;
	typedef struct packed {
		logic [1:0] kind;
		logic [31:0] addr;
		logic [31:0] data;
		logic bl;
		logic ll;
		logic [3:0] pend;
	} mof_rec_t;
	logic clock_i, rstn_i, op_valid_i, op_uncached_i, older_done_i, op_ready_o, resp_valid_o;
	logic bus_req_o, bus_lock_o, line_lock_o, bus_gnt_i, bus_ack_i, drained_o;
	mof_pkg::mof_op_t op_kind_i;
	mof_pkg::mof_bus_t bus_kind_o;
	logic [31:0] op_addr_i, op_data_i, resp_data_o, bus_addr_o, bus_data_o, bus_rdata_i;
	logic [3:0] lat, pend;
	mof_rec_t log [$];
	int n_errors = 0;
	int cmp_count = 0;

	mof_fence_unit i_mof_fence_unit (.clock_i(clock_i), .rstn_i(rstn_i), .op_valid_i(op_valid_i),
		.op_kind_i(op_kind_i), .op_addr_i(op_addr_i), .op_data_i(op_data_i), .op_uncached_i(op_uncached_i),
		.older_done_i(older_done_i), .op_ready_o(op_ready_o), .resp_valid_o(resp_valid_o),
		.resp_data_o(resp_data_o), .bus_req_o(bus_req_o), .bus_kind_o(bus_kind_o), .bus_addr_o(bus_addr_o),
		.bus_data_o(bus_data_o), .bus_lock_o(bus_lock_o), .line_lock_o(line_lock_o), .bus_gnt_i(bus_gnt_i),
		.bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i), .drained_o(drained_o));
	mof_mem_model i_mof_mem_model (.clock_i(clock_i), .rstn_i(rstn_i), .lat_i(lat), .bus_req_i(bus_req_o),
		.bus_kind_i(bus_kind_o), .bus_addr_i(bus_addr_o), .bus_data_i(bus_data_o), .bus_gnt_o(bus_gnt_i),
		.bus_ack_o(bus_ack_i), .bus_rdata_o(bus_rdata_i), .pend_o(pend));

	// Every granted bus cycle is logged with its locks and the writes still open.
	always @(posedge clock_i) begin
		if (bus_req_o && bus_gnt_i)
			log.push_back({bus_kind_o, bus_addr_o, bus_data_o, bus_lock_o, line_lock_o, pend});
	end

	// ----------------------------------------------------------------
	// Common tasks
	// ----------------------------------------------------------------
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_flag(input string what, input logic exp, input logic got);
		chk_word(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
	endtask
	task automatic close_out();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic give_up();
		n_errors++;
		close_out();
	endtask
	// Flags are looked at on the falling edge, where they are settled.
	task automatic wait_flag(input int sel);
		int i;
		i = 0;
		do begin
			@(negedge clock_i);
			i++;
		end while ((sel == 0 ? op_ready_o : drained_o) !== 1'b1 && i < 300);
		if ((sel == 0 ? op_ready_o : drained_o) !== 1'b1)
			give_up();
	endtask
	task automatic wait_resp(output logic [31:0] r, output logic early);
		int i;
		i = 0;
		early = 1'b0;
		do begin
			@(negedge clock_i);
			i++;
			if (resp_valid_o !== 1'b1 && op_ready_o === 1'b1)
				early = 1'b1;
		end while (resp_valid_o !== 1'b1 && i < 300);
		if (resp_valid_o !== 1'b1)
			give_up();
		r = resp_data_o;
	endtask
	// The request stands until the edge at which ready is seen high.
	task automatic offer(input mof_pkg::mof_op_t k, input logic [31:0] a, input logic [31:0] d, input logic uc);
		@(posedge clock_i);
		op_valid_i <= 1'b1;
		op_kind_i <= k;
		op_addr_i <= a;
		op_data_i <= d;
		op_uncached_i <= uc;
		wait_flag(0);
		@(posedge clock_i);
		op_valid_i <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_port();
		logic [31:0] r;
		logic e;
		lat <= 4'h3;
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_0100, 32'h1111_aaaa, 1'b0);
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_0200, 32'h2222_bbbb, 1'b0);
		offer(mof_pkg::MOF_OP_PORT_IN, 32'h0000_0060, 32'h0000_0000, 1'b0);
		wait_resp(r, e);
		chk_word("port in data", 32'h0000_0060 ^ 32'h5a5a_5a5a, r);
		chk_flag("ready before port done", 1'b0, e);
		chk_word("bus cycles", 32'h0000_0003, log.size());
		chk_word("older write", 32'h0000_0100, log[0].addr);
		chk_word("buffered data", 32'h2222_bbbb, log[1].data);
		chk_word("port kind", 32'(mof_pkg::MOF_BUS_PORT_RD), 32'(log[2].kind));
		chk_word("open writes at port", 32'h0000_0000, 32'(log[2].pend));
		lat <= 4'h0;
	endtask
	// A slow grant keeps the later stores in the buffer, so the two stores to
	// one address combine and the load is answered from the buffer.
	task automatic sc_fwd();
		logic [31:0] r;
		logic e;
		int n;
		log.delete();
		lat <= 4'h6;
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_02f0, 32'h0000_0001, 1'b0);
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_02f4, 32'h0000_0002, 1'b0);
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_0300, 32'h3333_0000, 1'b0);
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_0300, 32'h3333_cccc, 1'b0);
		offer(mof_pkg::MOF_OP_LOAD, 32'h0000_0300, 32'h0000_0000, 1'b0);
		wait_resp(r, e);
		chk_word("own store to load", 32'h3333_cccc, r);
		n = 0;
		foreach (log[j]) begin
			if (log[j].kind == mof_pkg::MOF_BUS_READ)
				n++;
		end
		chk_word("bus reads for forwarded load", 32'h0000_0000, n);
		wait_flag(1);
		n = 0;
		foreach (log[j]) begin
			if (log[j].addr == 32'h0000_0300)
				n++;
		end
		chk_word("combined writes", 32'h0000_0001, n);
		lat <= 4'h0;
		offer(mof_pkg::MOF_OP_LOAD, 32'h0000_0100, 32'h0000_0000, 1'b0);
		wait_resp(r, e);
		chk_word("load after drain", 32'h1111_aaaa, r);
	endtask
	task automatic sc_locked();
		logic [31:0] r;
		logic e;
		wait_flag(1);
		log.delete();
		lat <= 4'h2;
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_0410, 32'h4444_0000, 1'b0);
		offer(mof_pkg::MOF_OP_LOCKED_RMW, 32'h0000_0400, 32'h4444_dddd, 1'b0);
		wait_resp(r, e);
		wait_flag(0);
		chk_word("rmw old value", 32'h0000_0400 ^ 32'h5a5a_5a5a, r);
		chk_word("rmw cycles", 32'h0000_0003, log.size());
		chk_word("open writes at rmw", 32'h0000_0000, 32'(log[1].pend));
		chk_word("rmw write data", 32'h4444_dddd, log[2].data);
		chk_flag("line lock in line", 1'b1, log[1].ll & log[2].ll);
		chk_flag("bus lock in line", 1'b0, log[1].bl | log[2].bl);
		log.delete();
		offer(mof_pkg::MOF_OP_LOCKED_RMW, 32'h0000_043e, 32'h5555_eeee, 1'b0);
		wait_resp(r, e);
		wait_flag(0);
		chk_flag("bus lock split", 1'b1, log[0].bl & log[1].bl);
		chk_word("split write kind", 32'(mof_pkg::MOF_BUS_WRITE), 32'(log[1].kind));
		chk_flag("locks released", 1'b0, bus_lock_o | line_lock_o);
		lat <= 4'h0;
	endtask
	task automatic sc_uncached();
		logic [31:0] r;
		logic e;
		log.delete();
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_0500, 32'h6666_0001, 1'b1);
		offer(mof_pkg::MOF_OP_STORE, 32'h0000_0504, 32'h6666_0002, 1'b1);
		offer(mof_pkg::MOF_OP_LOAD, 32'h0000_0500, 32'h0000_0000, 1'b1);
		wait_resp(r, e);
		wait_flag(0);
		chk_word("uncached cycles", 32'h0000_0003, log.size());
		chk_word("uncached order", 32'h0000_0504, log[1].addr);
		chk_word("uncached read kind", 32'(mof_pkg::MOF_BUS_READ), 32'(log[2].kind));
		chk_word("uncached load data", 32'h6666_0001, r);
	endtask
	task automatic sc_fence();
		mof_pkg::mof_op_t k [3] = '{mof_pkg::MOF_OP_STORE_FENCE, mof_pkg::MOF_OP_FULL_FENCE,
			mof_pkg::MOF_OP_SERIALIZE};
		logic [31:0] r;
		logic e;
		int hold;
		lat <= 4'h4;
		for (int i = 0; i < 3; i++) begin
			wait_flag(1);
			log.delete();
			hold = 0;
			if (i == 2)
				older_done_i <= 1'b0;
			offer(mof_pkg::MOF_OP_STORE, 32'h0000_0700 + 32'(i), 32'h7777_0000 + 32'(i), 1'b0);
			offer(k[i], 32'h0000_0000, 32'h0000_0000, 1'b0);
			repeat (8) begin
				@(negedge clock_i);
				if (i == 2 && op_ready_o !== 1'b0)
					hold++;
			end
			older_done_i <= 1'b1;
			wait_flag(0);
			chk_word("ready while older busy", 32'h0000_0000, hold);
			chk_word("fence write seen", 32'h0000_0001, log.size());
			chk_word("open writes at fence", 32'h0000_0000, 32'(pend));
		end
		offer(mof_pkg::MOF_OP_LOAD_FENCE, 32'h0000_0000, 32'h0000_0000, 1'b0);
		offer(mof_pkg::MOF_OP_LOAD, 32'h0000_0504, 32'h0000_0000, 1'b0);
		wait_resp(r, e);
		chk_word("load past load fence", 32'h6666_0002, r);
		lat <= 4'h0;
	endtask

	// ----------------------------------------------------------------
	// Clock and main sequence
	// ----------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		rstn_i = 1'b0;
		op_valid_i = 1'b0;
		op_kind_i = mof_pkg::MOF_OP_LOAD;
		op_addr_i = 32'h0000_0000;
		op_data_i = 32'h0000_0000;
		op_uncached_i = 1'b0;
		older_done_i = 1'b1;
		lat = 4'h0;
		repeat (12) @(posedge clock_i);
		rstn_i <= 1'b1;
		sc_port();
		sc_fwd();
		sc_locked();
		sc_uncached();
		sc_fence();
		wait_flag(1);
		chk_flag("drained at end", 1'b1, drained_o);
		close_out();
	end
endmodule
